// [wtb_pkg.sv]
`default_nettype none
package wtb_pkg;

    // Register byte offsets inside the instance window
    localparam logic [7:0]  OFS_RELOAD     = 8'h00;
    localparam logic [7:0]  OFS_CONTROL    = 8'h04;
    localparam logic [7:0]  OFS_RESTART    = 8'h08;
    localparam logic [7:0]  OFS_COUNT      = 8'h0C;
    localparam logic [7:0]  OFS_STATUS     = 8'h10;

    // Control and status field positions
    localparam int          BIT_RUN        = 0;
    localparam int          BIT_SLEEP0     = 2;
    localparam int          BIT_WEEK       = 3;
    localparam int          BIT_DEBUG      = 4;
    localparam int          BIT_EXPIRED    = 0;

    // Reset values
    localparam logic [15:0] RELOAD_RST     = 16'hFFFF;
    localparam logic [15:0] COUNT_RST      = 16'hFFFF;
    localparam logic [3:0]  CONTROL_RST    = 4'h0;

    // Timing: the slow clock and slow periods per count step
    localparam int          SLOW_CLK_HZ    = 32768;
    localparam int          TICKS_PER_STEP = 33;
    localparam int          HCLK_HZ        = 50_000_000;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_RELOAD,
        SEL_CONTROL,
        SEL_RESTART,
        SEL_COUNT,
        SEL_STATUS
    } wtb_sel_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_RDWAIT
    } wtb_bus_t;

    typedef struct packed {
        logic debug_hold_enable;
        logic week_timer_hold_enable;
        logic sleep_timer0_hold_enable;
        logic watchdog_run_enable;
    } wtb_ctrl_t;

endpackage : wtb_pkg
`default_nettype wire

// [wtb_watchdog.sv]
// Contract
// - Unreloaded expiry while enabled raises reset pulse
// - Register access runs on host clock only
// - Counting is paced by the 32KHz clock
// - System reset returns all state but the expiry flag to defaults
// - Persistent expiry flag uses keep-on-expiry reset
// - Expiry pulse resets subsystem, cleared by reset
// - Disable stops counting and idles the clock
// - Underflow sets the persistent expiry flag
// - Reload on load write, restart, or expiry
// - Interval is countdown from reload to zero
// - One count step per 33 slow periods
// - Enabled asserted hold stops count, idles clock
// - After hold, counting resumes from held value
// - Reload register RW, default FFFF, write reloads
// - Control bit 4 holds count during debug
// - Control bit 3 holds count on week timer
// - Control bit 2 holds count on sleep timer0
// - Control bit 0 enables counting, default zero
// - Registers at offsets 00, 04, 08, 0C
// - Restart write reloads only when enabled, reads zero
// - Count register reads live counter value
`default_nettype none
module wtb_watchdog
    import wtb_pkg::*;
#(
    parameter int TICKS = TICKS_PER_STEP
) (
    // Host clock and system reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Reset that survives an expiry
    input  wire logic        system_reset_keep_on_expiry_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Slow clock, sampled as a pin
    input  wire logic        slow_clk_32k,
    // Hold sources, on hclk
    input  wire logic        debug_active,
    input  wire logic        week_timer_active,
    input  wire logic        sleep_timer0_active,
    // Results
    output logic             expiry_reset_pulse,
    output logic             expiry_flag,
    output logic             clock_gate_idle
);

    localparam int PW = (TICKS > 1) ? $clog2(TICKS) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(TICKS - 1);

    function automatic wtb_sel_t reg_sel(input logic [7:0] a);
        wtb_sel_t s;
        s = SEL_NONE;
        if (a == OFS_RELOAD) begin
            s = SEL_RELOAD;
        end else if (a == OFS_CONTROL) begin
            s = SEL_CONTROL;
        end else if (a == OFS_RESTART) begin
            s = SEL_RESTART;
        end else if (a == OFS_COUNT) begin
            s = SEL_COUNT;
        end else if (a == OFS_STATUS) begin
            s = SEL_STATUS;
        end
        return s;
    endfunction : reg_sel

    wtb_bus_t        bus_state;
    wtb_sel_t        req_sel;
    wtb_ctrl_t       ctrl;
    logic [15:0]     reload_value;
    logic [15:0]     count;
    logic [PW-1:0]   pre_cnt;
    logic            slow_meta;
    logic            slow_s2;
    logic            slow_s3;
    logic            slow_lvl;
    logic            slow_rise;
    logic            accept;
    logic            accept_rd;
    logic            write_now;
    logic            load_wr;
    logic            kick_wr;
    logic            kick_live;
    logic            hold_now;
    logic            run_now;
    logic            step_now;
    logic            expiry_ev;
    logic            flag_clr;

    // Bus side
    assign accept    = hsel && htrans[1] && hready;
    assign accept_rd = accept && !hwrite;
    assign write_now = (bus_state == BUS_WRITE);
    assign load_wr   = write_now && (req_sel == SEL_RELOAD);
    assign kick_wr   = write_now && (req_sel == SEL_RESTART);
    assign kick_live = kick_wr && ctrl.watchdog_run_enable;
    assign flag_clr  = write_now && (req_sel == SEL_STATUS)
                       && hwdata[BIT_EXPIRED];

    // Counting side
    assign hold_now  = (ctrl.debug_hold_enable && debug_active)
                    || (ctrl.week_timer_hold_enable
                        && week_timer_active)
                    || (ctrl.sleep_timer0_hold_enable
                        && sleep_timer0_active);
    assign run_now   = ctrl.watchdog_run_enable && !hold_now;
    assign step_now  = run_now && slow_rise && (pre_cnt == PRE_LAST);
    assign expiry_ev = step_now && (count == 16'h0000)
                       && !load_wr && !kick_live;

    // Writes finish in their data phase; reads take one wait state so
    // the returned value already reflects a write just before it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= BUS_IDLE;
            req_sel   <= SEL_NONE;
        end else if (accept) begin
            bus_state <= hwrite ? BUS_WRITE : BUS_RDWAIT;
            req_sel   <= reg_sel(haddr[7:0]);
        end else if (bus_state != BUS_RDWAIT || !hreadyout) begin
            bus_state <= BUS_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= !accept_rd;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_state == BUS_RDWAIT && !hreadyout) begin
            hrdata <= 32'h0000_0000;
            case (req_sel)
                SEL_RELOAD: begin
                    hrdata[15:0] <= reload_value;
                end
                SEL_CONTROL: begin
                    hrdata[BIT_RUN]    <= ctrl.watchdog_run_enable;
                    hrdata[BIT_SLEEP0] <= ctrl.sleep_timer0_hold_enable;
                    hrdata[BIT_WEEK]   <= ctrl.week_timer_hold_enable;
                    hrdata[BIT_DEBUG]  <= ctrl.debug_hold_enable;
                end
                SEL_COUNT: begin
                    hrdata[15:0] <= count;
                end
                SEL_STATUS: begin
                    hrdata[BIT_EXPIRED] <= expiry_flag;
                end
                default: begin
                    hrdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_value <= RELOAD_RST;
        end else if (load_wr) begin
            reload_value <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= wtb_ctrl_t'(CONTROL_RST);
        end else if (write_now && req_sel == SEL_CONTROL) begin
            ctrl.watchdog_run_enable      <= hwdata[BIT_RUN];
            ctrl.sleep_timer0_hold_enable <= hwdata[BIT_SLEEP0];
            ctrl.week_timer_hold_enable   <= hwdata[BIT_WEEK];
            ctrl.debug_hold_enable        <= hwdata[BIT_DEBUG];
        end
    end

    // Slow clock passes three flops; a level change counts once the
    // second and third agree, so a glitch on the pin is filtered.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_meta <= 1'b0;
            slow_s2   <= 1'b0;
            slow_s3   <= 1'b0;
        end else begin
            slow_meta <= slow_clk_32k;
            slow_s2   <= slow_meta;
            slow_s3   <= slow_s2;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_lvl  <= 1'b0;
            slow_rise <= 1'b0;
        end else begin
            slow_rise <= 1'b0;
            if (slow_s2 == slow_s3 && slow_s3 != slow_lvl) begin
                slow_lvl  <= slow_s3;
                slow_rise <= slow_s3;
            end
        end
    end

    // A reload also restarts the prescaler so a fresh interval is whole.
    // Holding or disabling freezes both counter and prescaler in place.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count   <= COUNT_RST;
            pre_cnt <= '0;
        end else if (load_wr) begin
            count   <= hwdata[15:0];
            pre_cnt <= '0;
        end else if (kick_live) begin
            count   <= reload_value;
            pre_cnt <= '0;
        end else if (run_now && slow_rise) begin
            if (pre_cnt == PRE_LAST) begin
                pre_cnt <= '0;
                if (count == 16'h0000) begin
                    count <= reload_value;
                end else begin
                    count <= count - 16'h0001;
                end
            end else begin
                pre_cnt <= PW'(pre_cnt + 1'b1);
            end
        end
    end

    // Held until the system reset that it provokes arrives.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            expiry_reset_pulse <= 1'b0;
        end else if (expiry_ev) begin
            expiry_reset_pulse <= 1'b1;
        end
    end

    // Survives the system reset; a new expiry wins over a clear.
    always_ff @(posedge hclk or negedge system_reset_keep_on_expiry_n) begin
        if (!system_reset_keep_on_expiry_n) begin
            expiry_flag <= 1'b0;
        end else if (expiry_ev) begin
            expiry_flag <= 1'b1;
        end else if (flag_clr) begin
            expiry_flag <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_gate_idle <= 1'b1;
        end else begin
            clock_gate_idle <= !run_now;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_expiry_reload: assert property (
        expiry_ev |=> (count == $past(reload_value)) && expiry_reset_pulse
    ) else $error("expiry did not reload and pulse");

    chk_pulse_held: assert property (
        expiry_reset_pulse |=> expiry_reset_pulse [*8]
    ) else $error("expiry pulse dropped before reset");

    chk_flag_sticky: assert property (
        @(posedge hclk)
        disable iff (!system_reset_keep_on_expiry_n)
        expiry_ev |=> expiry_flag
    ) else $error("expiry flag not set");

    chk_disabled_frozen: assert property (
        !ctrl.watchdog_run_enable && !load_wr |=> $stable(count)
    ) else $error("count moved while disabled");

    chk_hold_frozen: assert property (
        hold_now && !load_wr && !kick_live
        |=> $stable(count) && $stable(pre_cnt)
    ) else $error("count moved during hold");

    chk_step_decrement: assert property (
        step_now && count != 16'h0000 && !load_wr && !kick_live
        |=> count == $past(count) - 16'h0001
    ) else $error("count step wrong");

    chk_load_reloads: assert property (
        load_wr |=> count == $past(hwdata[15:0])
                    && reload_value == $past(hwdata[15:0])
    ) else $error("load write did not reload");

    chk_restart_gate: assert property (
        kick_wr && !ctrl.watchdog_run_enable |=> $stable(count)
    ) else $error("restart acted while disabled");

    chk_read_wait: assert property (
        accept_rd |=> !hreadyout ##1 hreadyout
    ) else $error("read wait state wrong");

    chk_hold_idle_out: assert property (
        ctrl.watchdog_run_enable && debug_active
        && ctrl.debug_hold_enable |=> clock_gate_idle
    ) else $error("debug hold did not idle");

    chk_restart_reload: assert property (
        kick_live |=> count == $past(reload_value) && pre_cnt == '0
    ) else $error("restart did not reload");

    chk_flag_clear: assert property (
        @(posedge hclk)
        disable iff (!system_reset_keep_on_expiry_n)
        flag_clr && !expiry_ev |=> !expiry_flag
    ) else $error("expiry flag not cleared");

    cov_expiry: cover property (expiry_ev);
    cov_restart: cover property (kick_live);
    cov_hold: cover property (hold_now && ctrl.watchdog_run_enable);
    cov_count_read: cover property (
        bus_state == BUS_RDWAIT && req_sel == SEL_COUNT
    );

endmodule : wtb_watchdog
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb
    import wtb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Short prescale and a fast slow clock keep the run brief
    localparam int TK = 2;

    logic        hclk;
    logic        hresetn;
    logic        keep_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        slow_clk;
    logic        dbg_act;
    logic        week_act;
    logic        slp_act;
    logic        expiry_reset_pulse;
    logic        expiry_flag;
    logic        clock_gate_idle;
    logic [31:0] rd;
    logic [2:0]  src;
    logic        m_exp;
    logic        m_flag;
    int          miscompares;
    int          checks_done;
    int          cycles;
    int          seed;
    int          m_reload;
    int          m_count;
    int          m_ctrl;
    int          m_pre;

    wtb_watchdog #(.TICKS(TK)) i_wtb_watchdog (
        .hclk                          (hclk),
        .hresetn                       (hresetn),
        .system_reset_keep_on_expiry_n (keep_n),
        .hsel                          (hsel),
        .haddr                         (haddr),
        .htrans                        (htrans),
        .hwrite                        (hwrite),
        .hsize                         (hsize),
        .hwdata                        (hwdata),
        .hready                        (hreadyout),
        .hreadyout                     (hreadyout),
        .hresp                         (hresp),
        .hrdata                        (hrdata),
        .slow_clk_32k                  (slow_clk),
        .debug_active                  (dbg_act),
        .week_timer_active             (week_act),
        .sleep_timer0_active           (slp_act),
        .expiry_reset_pulse            (expiry_reset_pulse),
        .expiry_flag                   (expiry_flag),
        .clock_gate_idle               (clock_gate_idle)
    );

    always #10 hclk = ~hclk;

    task automatic tally_and_finish;
        $display("Checks: %0d, mismatches: %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        hsize  <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic reg_write(input logic [7:0] a, input int d);
        ahb(1'b1, a, d);
        if (a == OFS_RELOAD) begin
            m_reload = d & 32'hFFFF;
            m_count  = m_reload;
            m_pre    = 0;
        end
        if (a == OFS_CONTROL) begin
            m_ctrl = d & 32'h1D;
        end
        if (a == OFS_RESTART && m_ctrl[0]) begin
            m_count = m_reload;
            m_pre   = 0;
        end
        if (a == OFS_STATUS && d[0]) begin
            m_flag = 1'b0;
        end
    endtask : reg_write

    task automatic read_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(rd, exp);
        check({31'h0, hresp}, 32'h0);
    endtask : read_chk

    function automatic logic held();
        return (m_ctrl[4] & dbg_act) | (m_ctrl[3] & week_act)
             | (m_ctrl[2] & slp_act);
    endfunction : held

    // Slow edges are spaced widely so the pin synchroniser sees each one
    task automatic pulse_slow(input int n);
        repeat (n) begin
            repeat (8) @(posedge hclk);
            slow_clk <= 1'b1;
            if (m_ctrl[0] && !held()) begin
                m_pre++;
                if (m_pre == TK) begin
                    m_pre = 0;
                    if (m_count == 0) begin
                        m_count = m_reload;
                        m_exp   = 1'b1;
                        m_flag  = 1'b1;
                    end else begin
                        m_count--;
                    end
                end
            end
            repeat (8) @(posedge hclk);
            slow_clk <= 1'b0;
        end
        repeat (8) @(posedge hclk);
    endtask : pulse_slow

    task automatic cmp_all;
        read_chk(OFS_COUNT, m_count);
        check({31'h0, clock_gate_idle}, {31'h0, !m_ctrl[0] || held()});
        check({31'h0, expiry_reset_pulse}, {31'h0, m_exp});
        check({31'h0, expiry_flag}, {31'h0, m_flag});
    endtask : cmp_all

    task automatic do_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        m_reload = 32'hFFFF;
        m_count  = 32'hFFFF;
        m_ctrl   = 0;
        m_pre    = 0;
        m_exp    = 1'b0;
    endtask : do_reset

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        keep_n = 1'b0;
        {hsel, hwrite, slow_clk, dbg_act, week_act, slp_act} = 6'h00;
        haddr = 32'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        hwdata = 32'h0;
        seed = 32'hf71f;
        m_flag = 1'b0;
        do_reset();
        keep_n <= 1'b1;
        read_chk(OFS_RELOAD, 32'hFFFF);
        read_chk(OFS_CONTROL, 32'h0);
        read_chk(OFS_RESTART, 32'h0);
        cmp_all();
        reg_write(8'h14, 32'h1234);
        read_chk(8'h14, 32'h0);
        read_chk(OFS_RELOAD, 32'hFFFF);
        $display("Test 1 done");
        reg_write(OFS_CONTROL, 32'hFF);
        read_chk(OFS_CONTROL, 32'h1D);
        reg_write(OFS_CONTROL, 32'h0);
        repeat (3) begin
            reg_write(OFS_RELOAD, $random(seed));
            read_chk(OFS_RELOAD, m_reload);
            cmp_all();
        end
        $display("Test 2 done");
        reg_write(OFS_RELOAD, 3);
        reg_write(OFS_CONTROL, 1);
        pulse_slow(3 * TK);
        cmp_all();
        pulse_slow(TK - 1);
        cmp_all();
        pulse_slow(1);
        cmp_all();
        pulse_slow(TK);
        cmp_all();
        $display("Test 3 done");
        reg_write(OFS_CONTROL, 0);
        reg_write(OFS_RESTART, 32'hA5);
        pulse_slow(TK);
        cmp_all();
        read_chk(OFS_RESTART, 32'h0);
        reg_write(OFS_CONTROL, 1);
        reg_write(OFS_RESTART, 32'h5A);
        cmp_all();
        $display("Test 4 done");
        reg_write(OFS_RELOAD, 32'h100);
        for (int i = 0; i < 3; i++) begin
            src = 3'($random(seed)) | (3'b001 << i);
            {dbg_act, week_act, slp_act} <= src;
            reg_write(OFS_CONTROL, 1);
            pulse_slow(TK);
            cmp_all();
            reg_write(OFS_CONTROL, 1 | (1 << (BIT_SLEEP0 + i)));
            pulse_slow(TK);
            cmp_all();
            {dbg_act, week_act, slp_act} <= src & ~(3'b001 << i);
            pulse_slow(TK);
            cmp_all();
        end
        {dbg_act, week_act, slp_act} <= 3'b000;
        $display("Test 5 done");
        do_reset();
        read_chk(OFS_RELOAD, 32'hFFFF);
        read_chk(OFS_CONTROL, 32'h0);
        cmp_all();
        read_chk(OFS_STATUS, {31'h0, m_flag});
        @(posedge hclk);
        keep_n <= 1'b0;
        @(posedge hclk);
        keep_n <= 1'b1;
        m_flag = 1'b0;
        cmp_all();
        reg_write(OFS_RELOAD, 0);
        reg_write(OFS_CONTROL, 1);
        pulse_slow(TK);
        cmp_all();
        reg_write(OFS_STATUS, 32'h1);
        cmp_all();
        $display("Test 6 done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
